// File: design/aisf_consts.svh
// constants for the identify-word and set-features block
// assumes inclusion by the design module, the host model and the bench
`ifndef AISF_CONSTS_SVH
`define AISF_CONSTS_SVH
`define AISF_OFS_SUBCMD     3'h1
`define AISF_OFS_CONFIG     3'h2
`define AISF_OFS_SECIDX     3'h3
`define AISF_OFS_TRKLO      3'h4
`define AISF_OFS_TRKHI      3'h5
`define AISF_OFS_DRVHD      3'h6
`define AISF_OFS_OPCODE     3'h7
`define AISF_OFS_DATA       3'h0
`define AISF_OP_SETFEAT     8'hef
`define AISF_OP_IDENTIFY    8'hec
`define AISF_SF_XFER        8'h03
`define AISF_SF_WC_ON       8'h02
`define AISF_SF_WC_OFF      8'h82
`define AISF_XT_PIO         5'h01
`define AISF_XT_MDMA        5'h04
`define AISF_XT_UDMA        5'h08
`define AISF_W87            16'h4000
`define AISF_W217           16'h0001
`define AISF_SIGNATURE      8'ha5
`define AISF_UDMA_MAX       3'h6
`define AISF_DRV_BIT        4
`define AISF_MTH_JUMPER     2'h1
`define AISF_MTH_CSEL       2'h2
`define AISF_MTH_OTHER      2'h3
`define AISF_ERASE_N        8'h00
`define AISF_ERASE_E        8'h00
`endif

// File: design/aisf_ident.sv
// identify words 87..255 generator and set-features taskfile decoder
// assumes synchronous taskfile strobes, one access per cycle, and that
// the host loads the taskfile before writing the opcode
`include "aisf_consts.svh"
module aisf_ident (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        hw_reset_in,
  input  wire logic        cblid_in,
  input  wire logic        is_dev1_in,
  input  wire logic [1:0]  dev_method_in,
  input  wire logic        pdiag_seen_in,
  input  wire logic        dasp_seen_in,
  input  wire logic        dev0_resp_in,
  input  wire logic        diag_pass_in,
  input  wire logic        sec_max_in,
  input  wire logic        sec_frozen_in,
  input  wire logic        sec_locked_in,
  input  wire logic        sec_enabled_in,
  input  wire logic        sec_fail_in,
  input  wire logic        flush_done_in,
  input  wire logic [2:0]  addr_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic [15:0] base_word_in,
  output logic [15:0] rdata_out,
  output logic        rvalid_out,
  output logic [7:0]  word_idx_out,
  output logic        busy_out,
  output logic        done_out,
  output logic        abort_out,
  output logic        flush_req_out,
  output logic        wcache_out,
  output logic        sec_expired_out,
  output logic [6:0]  udma_sel_out
);
  aisf_pkg::aisf_state_s st_reg;
  aisf_pkg::aisf_state_s st_next;

  logic [15:0] word;
  logic [7:0]  w_sum;
  logic [15:0] w88;
  logic [15:0] w93;
  logic [15:0] w128;
  logic [15:0] w255;
  logic [12:0] w93_cap;
  logic        xfer_ok;
  logic        rd_data;

  // supported modes 6 down to 0
  assign w88 = {1'b0, st_reg.udma_sel, 1'b0, 7'h7f};
  assign w128 = {7'h00, sec_max_in & sec_enabled_in, 2'h0,
                 1'b1, st_reg.expired, sec_frozen_in,
                 sec_locked_in, sec_enabled_in, 1'b1};
  // field bit 12 stores word bit 13; word bit 12 is reserved
  assign w93 = {2'b01, st_reg.w93[12], 1'b0, st_reg.w93[11:0]};
  assign w255 = {8'(8'h00 - st_reg.csum - `AISF_SIGNATURE),
                 `AISF_SIGNATURE};

  // live capture image of reset results
  always_comb
  begin
    w93_cap = 13'h0000;
    w93_cap[12] = cblid_in;
    if (is_dev1_in)
    begin
      w93_cap[11:8] = {pdiag_seen_in, dev_method_in, 1'b1};
    end
    else
    begin
      w93_cap[6:0] = {dev0_resp_in, dasp_seen_in, pdiag_seen_in,
                      diag_pass_in, dev_method_in, 1'b1};
    end
  end

  // word mux; words below 87 come from outside
  always_comb
  begin
    unique case (st_reg.widx)
      8'd87:   word = `AISF_W87;
      8'd88:   word = w88;
      8'd89:   word = {8'h00, `AISF_ERASE_N};
      8'd90:   word = {8'h00, `AISF_ERASE_E};
      8'd93:   word = w93;
      8'd128:  word = w128;
      8'd217:  word = `AISF_W217;
      8'd255:  word = w255;
      default: word = (st_reg.widx < 8'd87) ? base_word_in : 16'h0000;
    endcase
  end

  assign w_sum = 8'(st_reg.csum + word[7:0] + word[15:8]);
  assign xfer_ok = (st_reg.config_v[7:3] == `AISF_XT_PIO) ||
                   (st_reg.config_v[7:3] == `AISF_XT_MDMA) ||
                   ((st_reg.config_v[7:3] == `AISF_XT_UDMA) &&
                    (st_reg.config_v[2:0] <= `AISF_UDMA_MAX));
  assign rd_data = rd_in && (addr_in == `AISF_OFS_DATA);

  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.abort = 1'b0;
    st_next.rvalid = 1'b0;
    if (hw_reset_in)
    begin
      st_next.w93 = w93_cap;
      st_next.expired = 1'b0;
    end
    else if (sec_fail_in)
    begin
      st_next.expired = 1'b1;
    end
    unique case (st_reg.state)
      aisf_pkg::AISF_IDLE:
      begin
        if (wr_in)
        begin
          unique case (addr_in)
            `AISF_OFS_SUBCMD: st_next.subcmd = wdata_in;
            `AISF_OFS_CONFIG: st_next.config_v = wdata_in;
            `AISF_OFS_SECIDX: st_next.secidx = wdata_in;
            `AISF_OFS_TRKLO:  st_next.trklo = wdata_in;
            `AISF_OFS_TRKHI:  st_next.trkhi = wdata_in;
            `AISF_OFS_DRVHD:  st_next.drvhd = wdata_in;
            `AISF_OFS_OPCODE:
            begin
              if (st_reg.drvhd[`AISF_DRV_BIT] != is_dev1_in)
              begin
                st_next.abort = 1'b0;
              end
              else if (wdata_in == `AISF_OP_IDENTIFY)
              begin
                st_next.state = aisf_pkg::AISF_SEND;
                st_next.widx = 8'h00;
                st_next.csum = 8'h00;
                st_next.busy = 1'b1;
              end
              else if (wdata_in == `AISF_OP_SETFEAT)
              begin
                if (st_reg.subcmd == `AISF_SF_XFER)
                begin
                  if (!xfer_ok)
                  begin
                    st_next.abort = 1'b1;
                  end
                  else
                  begin
                    if (st_reg.config_v[7:3] == `AISF_XT_UDMA)
                    begin
                      st_next.udma_sel = 7'(7'h01 << st_reg.config_v[2:0]);
                    end
                    else
                    begin
                      st_next.udma_sel = 7'h00;
                    end
                    st_next.done = 1'b1;
                  end
                end
                else if (st_reg.subcmd == `AISF_SF_WC_OFF)
                begin
                  st_next.wcache = 1'b0;
                  st_next.flush_req = 1'b1;
                  st_next.busy = 1'b1;
                  st_next.state = aisf_pkg::AISF_FLUSH;
                end
                else
                begin
                  if (st_reg.subcmd == `AISF_SF_WC_ON)
                  begin
                    st_next.wcache = 1'b1;
                  end
                  st_next.done = 1'b1;
                end
              end
              else
              begin
                st_next.abort = 1'b1;
              end
            end
            default:
            begin
              st_next.state = st_reg.state;
            end
          endcase
        end
      end
      aisf_pkg::AISF_FLUSH:
      begin
        if (flush_done_in)
        begin
          st_next.flush_req = 1'b0;
          st_next.busy = 1'b0;
          st_next.done = 1'b1;
          st_next.state = aisf_pkg::AISF_IDLE;
        end
      end
      aisf_pkg::AISF_SEND:
      begin
        if (rd_data)
        begin
          st_next.rvalid = 1'b1;
          if (st_reg.widx == 8'hff)
          begin
            st_next.rdata = w255;
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
            st_next.state = aisf_pkg::AISF_IDLE;
          end
          else
          begin
            st_next.rdata = word;
            st_next.csum = w_sum;
            st_next.widx = 8'(st_reg.widx + 8'h01);
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      st_reg <= '0;
      st_reg.state <= aisf_pkg::AISF_IDLE;
      st_reg.w93 <= 13'h0000;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rdata_out = st_reg.rdata;
  assign rvalid_out = st_reg.rvalid;
  assign word_idx_out = st_reg.widx;
  assign busy_out = st_reg.busy;
  assign done_out = st_reg.done;
  assign abort_out = st_reg.abort;
  assign flush_req_out = st_reg.flush_req;
  assign wcache_out = st_reg.wcache;
  assign sec_expired_out = st_reg.expired;
  assign udma_sel_out = st_reg.udma_sel;

  a_w93_hold: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !hw_reset_in |=> st_reg.w93 == $past(st_reg.w93))
    else $error("reset result changed outside hardware reset");
  a_w93_capt: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    hw_reset_in |=> st_reg.w93[12] == $past(cblid_in))
    else $error("cable id not captured");
  a_dev_zero: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    hw_reset_in && is_dev1_in |=> st_reg.w93[7:0] == 8'h00)
    else $error("device 0 field not zero on device 1");
  a_dev1_zero: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    hw_reset_in && !is_dev1_in |=> st_reg.w93[11:8] == 4'h0)
    else $error("device 1 field not zero on device 0");
  a_expire_sticky: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    st_reg.expired && !hw_reset_in |=> st_reg.expired)
    else $error("expired flag dropped without reset");
  a_udma_onehot: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    $onehot0(st_reg.udma_sel))
    else $error("more than one ultra dma mode selected");
  a_flush_first: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    st_reg.state == aisf_pkg::AISF_FLUSH && !flush_done_in
    |=> !st_reg.done)
    else $error("completion before flush");
  a_idx_step: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    st_reg.state == aisf_pkg::AISF_SEND && rd_data && st_reg.widx != 8'hff
    |=> st_reg.widx == 8'($past(st_reg.widx) + 8'h01) && st_reg.rvalid)
    else $error("identify word index did not advance");
  a_sig_last: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    st_reg.state == aisf_pkg::AISF_SEND && rd_data && st_reg.widx == 8'hff
    |=> st_reg.rdata[7:0] == `AISF_SIGNATURE && st_reg.done)
    else $error("integrity word signature wrong");
endmodule

// File: design/aisf_pkg.sv
// types for the identify-word and set-features block
// assumes the constants header is compiled alongside
package aisf_pkg;
  typedef enum logic [1:0] {
    AISF_IDLE,
    AISF_FLUSH,
    AISF_SEND
  } aisf_state_e;

  typedef struct packed {
    aisf_state_e state;
    logic [7:0]  subcmd;
    logic [7:0]  config_v;
    logic [7:0]  secidx;
    logic [7:0]  trklo;
    logic [7:0]  trkhi;
    logic [7:0]  drvhd;
    logic [6:0]  udma_sel;
    logic        wcache;
    logic [12:0] w93;
    logic        expired;
    logic [7:0]  widx;
    logic [7:0]  csum;
    logic [15:0] rdata;
    logic        rvalid;
    logic        busy;
    logic        done;
    logic        abort;
    logic        flush_req;
  } aisf_state_s;
endpackage

// File: sim/aisf_host.sv
// host controller model driving the taskfile strobes
// assumes the device samples strobes on the rising clock edge
`include "aisf_consts.svh"
module aisf_host (
  input  wire logic        mclk_in,
  input  wire logic [15:0] rdata_in,
  output logic [2:0]       addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic [7:0]       wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    addr_out = 3'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge mclk_in);
    wr_out = 1'b0;
    wdata_out = ~d;
  endtask
  task automatic rd_word(output logic [15:0] d);
    @(negedge mclk_in);
    addr_out = `AISF_OFS_DATA;
    rd_out = 1'b1;
    @(negedge mclk_in);
    d = rdata_in;
    rd_out = 1'b0;
  endtask
  // taskfile loaded before the opcode
  task automatic set_feature(input logic [7:0] sub, cfg, drv);
    wr_reg(`AISF_OFS_SUBCMD, sub);
    wr_reg(`AISF_OFS_CONFIG, cfg);
    wr_reg(`AISF_OFS_DRVHD, drv);
    wr_reg(`AISF_OFS_OPCODE, `AISF_OP_SETFEAT);
  endtask
endmodule

// File: sim/test_aisf_ident.sv
// self-checking bench for the identify and set-features block
// assumes the host model drives the taskfile at falling edges
`include "aisf_consts.svh"
module test_aisf_ident;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, hw_rst, cblid, dev1, pdiag, dasp, resp, diag;
  logic smax, sfroz, slock, sen, sfail, fdone, rd, wr;
  logic rvalid, busy, done, abort, freq, wc, expd;
  logic [1:0]  meth;
  logic [2:0]  addr;
  logic [6:0]  usel;
  logic [7:0]  wdata, idx;
  logic [15:0] base, rdata, w;
  int          errors, comparisons, cycles;
  assign base = {idx, 8'h3c};
  aisf_host host (.mclk_in(mclk), .rdata_in(rdata), .addr_out(addr),
    .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  aisf_ident dut (.mclk_in(mclk), .nrst_in(nrst), .hw_reset_in(hw_rst),
    .cblid_in(cblid), .is_dev1_in(dev1), .dev_method_in(meth),
    .pdiag_seen_in(pdiag), .dasp_seen_in(dasp), .dev0_resp_in(resp),
    .diag_pass_in(diag), .sec_max_in(smax), .sec_frozen_in(sfroz),
    .sec_locked_in(slock), .sec_enabled_in(sen), .sec_fail_in(sfail),
    .flush_done_in(fdone), .addr_in(addr), .wr_in(wr), .rd_in(rd),
    .wdata_in(wdata), .base_word_in(base), .rdata_out(rdata),
    .rvalid_out(rvalid), .word_idx_out(idx), .busy_out(busy),
    .done_out(done), .abort_out(abort), .flush_req_out(freq),
    .wcache_out(wc), .sec_expired_out(expd), .udma_sel_out(usel));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic sf(input logic [7:0] sub, cfg, drv, input logic d, a);
    host.set_feature(sub, cfg, drv);
    chk("done", 16'(done), 16'(d));
    chk("abort", 16'(abort), 16'(a));
  endtask
  task automatic hwr();
    hw_rst = 1'b1;
    @(negedge mclk);
    hw_rst = 1'b0;
  endtask
  task automatic ident(input logic [15:0] e93, e128, e88,
                       input logic [7:0] drv);
    logic [7:0]  s;
    logic [15:0] e;
    s = 8'h00;
    host.wr_reg(`AISF_OFS_DRVHD, drv);
    host.wr_reg(`AISF_OFS_OPCODE, `AISF_OP_IDENTIFY);
    @(negedge mclk);
    chk("busy", 16'(busy), 16'h1);
    for (int i = 0; i < 256; i++)
    begin
      chk("index", 16'(idx), 16'(i));
      host.rd_word(w);
      chk("rvalid", 16'(rvalid), 16'h1);
      s = s + w[7:0] + w[15:8];
      e = (i < 87) ? {i[7:0], 8'h3c} : 16'h0000;
      case (i)
        87: e = `AISF_W87;
        88: e = e88;
        93: e = e93;
        128: e = e128;
        217: e = `AISF_W217;
        default: ;
      endcase
      if (i < 255)
        chk("word", w, e);
    end
    chk("signature", 16'(w[7:0]), 16'(`AISF_SIGNATURE));
    chk("byte sum", 16'(s), 16'h0);
    chk("done", 16'(done), 16'h1);
    chk("busy", 16'(busy), 16'h0);
  endtask
  initial
  begin
    {nrst, hw_rst, cblid, dev1, pdiag, dasp, resp, diag} = 8'h00;
    {smax, sfroz, slock, sen, sfail, fdone} = 6'h00;
    meth = 2'h0;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    chk("wcache", 16'(wc), 16'h0);
    chk("usel", 16'(usel), 16'h0);
    {cblid, pdiag, resp, diag, meth} = 6'h3d;
    hwr();
    {cblid, pdiag, meth} = 4'h3;
    sfail = 1'b1;
    @(negedge mclk);
    sfail = 1'b0;
    @(negedge mclk);
    chk("expired", 16'(expd), 16'h1);
    {sen, smax, sfroz} = 3'h7;
    sf(8'h03, 8'h0b, 8'h00, 1'b1, 1'b0);
    sf(8'h03, 8'h22, 8'h00, 1'b1, 1'b0);
    sf(8'h03, 8'h46, 8'h00, 1'b1, 1'b0);
    sf(8'h03, 8'h47, 8'h00, 1'b0, 1'b1);
    sf(8'h03, 8'h80, 8'h00, 1'b0, 1'b1);
    sf(8'h03, 8'h44, 8'h10, 1'b0, 1'b0);
    sf(8'h03, 8'h44, 8'h00, 1'b1, 1'b0);
    chk("usel", 16'(usel), 16'h10);
    sf(`AISF_SF_WC_ON, 8'h00, 8'h00, 1'b1, 1'b0);
    chk("wcache", 16'(wc), 16'h1);
    sf(`AISF_SF_WC_OFF, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("flush req", 16'(freq), 16'h1);
    fdone = 1'b1;
    @(negedge mclk);
    fdone = 1'b0;
    chk("done", 16'(done), 16'h1);
    chk("wcache", 16'(wc), 16'h0);
    host.wr_reg(`AISF_OFS_OPCODE, 8'h00);
    chk("abort", 16'(abort), 16'h1);
    ident(16'h605b, 16'h013b, 16'h107f, 8'h00);
    {dev1, cblid, pdiag, meth, sen, slock, sfroz} = 8'hb6;
    hwr();
    chk("expired", 16'(expd), 16'h0);
    sf(8'h03, 8'h40, 8'h10, 1'b1, 1'b0);
    ident(16'h4d00, 16'h0127, 16'h017f, 8'h10);
    summarize();
  end
endmodule
